/* serial_eeprom_pkg.sv */
// Purpose: shared constants and types for the two-wire memory slave front end
// Assumes: one system clock; bus pins sampled asynchronously
// Notes: no registers, all control bits are plain ports
package serial_eeprom_pkg;

  // ==========================================================
  // select byte layout
  localparam logic [3:0] TYPE_ID_DEFAULT = 4'h5; // arbitrary neutral value
  localparam int SEL_RW_BIT = 0;
  localparam int SEL_CE_LO = 1;
  localparam int SEL_CE_HI = 3;
  localparam int SEL_TYPE_LO = 4;
  localparam int SEL_TYPE_HI = 7;
  localparam int BITS_PER_BYTE = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_ADDR_BITS = 4;
  localparam int ADDR_WIDTH = 11;

  // ==========================================================
  // pin sample and conditions seen on the bus
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_type;

  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } bus_events_type;

  // write port toward the array latches
  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic [7:0] data;
  } write_beat_type;

endpackage

/* bus_condition_detect.sv */
// Purpose: synchronise the two bus lines and find edges, start and stop
// Assumes: lines change slowly against the system clock
// Notes: first sync stage feeds only the second
`timescale 1ns/1ps
module bus_condition_detect (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // raw pins
  input wire serial_eeprom_pkg::bus_lines_type lines_i,
  // decoded events
  output serial_eeprom_pkg::bus_events_type events_o
);

  serial_eeprom_pkg::bus_lines_type meta_q;
  serial_eeprom_pkg::bus_lines_type sync_q;
  serial_eeprom_pkg::bus_lines_type prev_q;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else begin
      meta_q <= lines_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // ==========================================================
  // start and stop need clock high in both samples
  wire scl_held_high = sync_q.scl & prev_q.scl;
  assign events_o.start = scl_held_high & prev_q.sda & ~sync_q.sda;
  assign events_o.stop = scl_held_high & ~prev_q.sda & sync_q.sda;
  assign events_o.scl_rise = sync_q.scl & ~prev_q.scl;
  assign events_o.scl_fall = ~sync_q.scl & prev_q.scl;
  assign events_o.sda = sync_q.sda;

endmodule

/* serial_eeprom_slave.sv */
// Purpose: two-wire slave front end of a small serial memory
// Assumes: master drives the clock; bus sampled at 200 MHz
// Notes: array and programming timer sit outside; read data comes from a port
//
// Summary of operation
// - sample data on each rising clock edge while receiving.
// - start is data falling while clock is high.
// - stop is data rising while clock is high.
// - outside programming, watch for start and ignore everything else until one.
// - select byte msb first: type id, chip-enable code, read/write flag.
// - accept select only when type and chip-enable bits match pins.
// - larger parts use select bits 1 to 3 as address bits 8 to 10.
// - select bit 0 set means read, clear means write.
// - acknowledge select on ninth bit on match, else release and go standby.
// - transmitter releases after eight bits; receiver pulls low on ninth.
// - write select: ack select, receive and ack address, then wait data.
// - protected write still acks select and address, never data, no change.
// - protected if protect input high anytime from start to address end.
// - protect input low means writes allowed to the whole array.
// - stop after read gives standby with or without a master no-ack; any stop gives standby.
// - stop ending a write starts the programming cycle.
// - page write takes up to sixteen bytes, low four address bits wrap.
// - programming starts only on stop right after an acknowledge slot.
// - reads behave the same whatever the protect input.
`timescale 1ns/1ps
module serial_eeprom_slave #(
  parameter logic [3:0] TYPE_ID = serial_eeprom_pkg::TYPE_ID_DEFAULT,
  // 0..3: select bits taken as high address bits
  parameter int HIGH_ADDR_BITS = 3
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // strap pins
  input wire logic chip_sel_pin_0_i,
  input wire logic chip_sel_pin_1_i,
  input wire logic chip_sel_pin_2_i,
  input wire logic write_protect_n_i,
  // array side
  input wire logic busy_i,
  input wire logic [7:0] read_data_i,
  output logic [serial_eeprom_pkg::ADDR_WIDTH-1:0] addr_o,
  output serial_eeprom_pkg::write_beat_type write_beat_o,
  output logic write_beat_valid_o,
  output logic read_advance_o,
  output logic program_start_o,
  output logic selected_o
);

  localparam int AW = serial_eeprom_pkg::ADDR_WIDTH;
  localparam int BW = serial_eeprom_pkg::BITS_PER_BYTE;
  // count once the ack clock has risen
  localparam logic [3:0] ACK_DONE = serial_eeprom_pkg::ACK_SLOT + 4'h1;

  if (HIGH_ADDR_BITS < 0 || HIGH_ADDR_BITS > 3) begin : g_bad_high_bits
    $error("HIGH_ADDR_BITS must be 0 to 3");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SELECT,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_RACK
  } phase_type;

  // ==========================================================
  // synchronised straps; protect pin is level-only
  logic [3:0] strap_meta_q;
  logic [3:0] strap_q;
  logic busy_meta_q;
  logic busy_q;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      strap_meta_q <= 4'h0;
      strap_q <= 4'h0;
      busy_meta_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      strap_meta_q <= {write_protect_n_i, chip_sel_pin_2_i, chip_sel_pin_1_i,
        chip_sel_pin_0_i};
      strap_q <= strap_meta_q;
      busy_meta_q <= busy_i;
      busy_q <= busy_meta_q;
    end
  end

  // protect input is active high per pin level; low means writes open
  wire protect_level = strap_q[3];

  serial_eeprom_pkg::bus_events_type ev;
  serial_eeprom_pkg::bus_lines_type bus_pins;

  assign bus_pins = '{scl: scl_i, sda: sda_i};

  bus_condition_detect u_detect (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .lines_i(bus_pins),
    .events_o(ev)
  );

  // ==========================================================
  // select decode
  function automatic logic select_match(input logic [7:0] sel, input logic [2:0] ce,
      input logic [3:0] tid);
    logic ok;
    ok = (sel[serial_eeprom_pkg::SEL_TYPE_HI:serial_eeprom_pkg::SEL_TYPE_LO] == tid);
    for (int i = 0; i < 3; i++) begin
      if (i >= HIGH_ADDR_BITS && sel[serial_eeprom_pkg::SEL_CE_LO + i] != ce[i]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  phase_type phase_q, phase_d;
  logic [7:0] shift_q;
  logic [3:0] bit_q;
  logic ack_drive_q;
  logic protect_q;
  logic wrote_q;
  logic after_ack_q;
  logic master_nack_q;
  logic [AW-1:0] addr_q;
  logic sda_low_q;

  wire [7:0] rx_byte = {shift_q[6:0], ev.sda};
  wire in_ack_slot = (bit_q == serial_eeprom_pkg::ACK_SLOT);
  // fall after the ack clock closes the nine-clock frame
  wire frame_end = ev.scl_fall & (bit_q == ACK_DONE);
  wire rx_phase = (phase_q == ST_SELECT) || (phase_q == ST_ADDR) || (phase_q == ST_WDATA);
  wire sample_bit = ev.scl_rise & rx_phase & (bit_q < 4'(BW));
  wire byte_done = sample_bit & (bit_q == 4'(BW - 1));
  wire sel_ok = select_match(rx_byte, strap_q[2:0], TYPE_ID);
  wire is_read = rx_byte[serial_eeprom_pkg::SEL_RW_BIT];
  wire [2:0] sel_hi = rx_byte[serial_eeprom_pkg::SEL_CE_HI:serial_eeprom_pkg::SEL_CE_LO];
  wire [AW-1:0] hi_mask = AW'(((1 << HIGH_ADDR_BITS) - 1) << BW);
  wire [AW-1:0] page_next = {addr_q[AW-1:serial_eeprom_pkg::PAGE_ADDR_BITS],
    addr_q[serial_eeprom_pkg::PAGE_ADDR_BITS-1:0] + 4'h1};
  wire [AW-1:0] seq_next = addr_q + 11'h001;
  wire write_prog = ev.stop & wrote_q & after_ack_q & ~protect_q;

  // ==========================================================
  // phase sequencing
  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      ST_IDLE: phase_d = phase_q;
      ST_SELECT: if (frame_end) begin
        phase_d = ack_drive_q ? (shift_q[serial_eeprom_pkg::SEL_RW_BIT] ? ST_RDATA : ST_ADDR)
          : ST_IDLE;
      end
      ST_ADDR: if (frame_end) begin
        phase_d = ST_WDATA;
      end
      ST_WDATA: phase_d = phase_q;
      ST_RDATA: if (ev.scl_fall && in_ack_slot) begin
        phase_d = ST_RACK;
      end
      ST_RACK: if (frame_end) begin
        phase_d = master_nack_q ? ST_IDLE : ST_RDATA;
      end
    endcase
    if (ev.start && !busy_q) begin
      phase_d = ST_SELECT;
    end else if (ev.stop || ev.start) begin
      phase_d = ST_IDLE;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      phase_q <= ST_IDLE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // ==========================================================
  // bit and byte handling
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      shift_q <= 8'h00;
      bit_q <= 4'h0;
      ack_drive_q <= 1'b0;
      protect_q <= 1'b0;
      wrote_q <= 1'b0;
      after_ack_q <= 1'b0;
      master_nack_q <= 1'b0;
      addr_q <= '0;
      write_beat_o <= '0;
      write_beat_valid_o <= 1'b0;
      read_advance_o <= 1'b0;
    end else begin
      write_beat_valid_o <= 1'b0;
      read_advance_o <= 1'b0;
      if (ev.start) begin
        bit_q <= 4'h0;
        ack_drive_q <= 1'b0;
        after_ack_q <= 1'b0;
        protect_q <= protect_level;
        if (phase_q != ST_ADDR) begin
          wrote_q <= 1'b0;
        end
      end else begin
        if ((phase_q == ST_SELECT || phase_q == ST_ADDR) && protect_level) begin
          protect_q <= 1'b1;
        end
        // only the slot right after an ack may hold a programming stop
        if (frame_end) begin
          after_ack_q <= 1'b1;
        end else if (ev.scl_fall) begin
          after_ack_q <= 1'b0;
        end
        if (ev.scl_rise && phase_q != ST_IDLE && bit_q != ACK_DONE) begin
          bit_q <= bit_q + 4'h1;
        end
        if (sample_bit) begin
          shift_q <= rx_byte;
        end
        if (byte_done) begin
          unique case (phase_q)
            ST_SELECT: begin
              ack_drive_q <= sel_ok;
              if (sel_ok) begin
                // a read select replaces the high bits and keeps the low byte
                addr_q <= ((AW'(sel_hi) << BW) & hi_mask)
                  | (is_read ? (addr_q & ~hi_mask) : '0);
              end
            end
            ST_ADDR: begin
              ack_drive_q <= 1'b1;
              addr_q <= {addr_q[AW-1:BW], rx_byte};
            end
            ST_WDATA: begin
              ack_drive_q <= ~protect_q;
              if (!protect_q) begin
                write_beat_o <= '{addr: addr_q, data: rx_byte};
                write_beat_valid_o <= 1'b1;
                wrote_q <= 1'b1;
              end
            end
            default: ack_drive_q <= 1'b0;
          endcase
        end
        if (frame_end) begin
          bit_q <= 4'h0;
          ack_drive_q <= 1'b0;
          if (phase_q == ST_WDATA && !protect_q) begin
            addr_q <= page_next;
          end
        end
        if (phase_q == ST_RDATA && ev.scl_fall && in_ack_slot) begin
          addr_q <= seq_next;
          read_advance_o <= 1'b1;
        end
        if (phase_q == ST_RACK && ev.scl_rise) begin
          master_nack_q <= ev.sda;
        end
      end
    end
  end

  // ==========================================================
  // open-drain data output: low only to ack or send a zero
  wire [2:0] rd_index = (bit_q == ACK_DONE) ? 3'(BW - 1) : 3'(BW - 1) - bit_q[2:0];
  // ack during the ninth clock, else the next read bit; master owns its ack
  wire want_low = in_ack_slot ? (ack_drive_q & rx_phase)
    : ((phase_d == ST_RDATA) & ~read_data_i[rd_index]);
  // change only after clock falls so master sees stable data
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sda_low_q <= 1'b0;
      sda_o <= 1'b0;
      sda_oe_n_o <= 1'b1;
      program_start_o <= 1'b0;
      selected_o <= 1'b0;
      addr_o <= '0;
    end else begin
      if (ev.scl_fall || ev.stop || ev.start) begin
        sda_low_q <= want_low & ~ev.stop & ~ev.start;
      end
      sda_o <= 1'b0;
      sda_oe_n_o <= ~sda_low_q;
      program_start_o <= write_prog;
      selected_o <= (phase_q != ST_IDLE) && (phase_q != ST_SELECT);
      addr_o <= addr_q;
    end
  end

endmodule

/* eeprom_slave_checker.sv */
// Purpose: bus-level checks on the two-wire memory slave front end
// Assumes: bound to serial_eeprom_slave, bus pins seen raw
// Notes: pin timing judged against the raw bus clock, not the synchronised one
`timescale 1ns/1ps
module eeprom_slave_checker (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // bus
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  // array side
  input wire logic busy_i,
  input wire logic write_beat_valid_o,
  input wire logic read_advance_o,
  input wire logic program_start_o,
  input wire logic selected_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // ==========
  // pin and pulse relations
  a_pull_low_only: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  a_drive_clock_low: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_n_o))
    else $error("data drive moved while bus clock high");
  a_prog_after_stop: assert property (program_start_o |-> scl_i && sda_i)
    else $error("programming start without stop");
  a_prog_one_pulse: assert property (program_start_o |=> !program_start_o [*8])
    else $error("programming start not a single pulse");
  a_beat_one_pulse: assert property (write_beat_valid_o |=> !write_beat_valid_o [*8])
    else $error("write beat repeated");
  a_beat_clock_high: assert property (write_beat_valid_o |-> scl_i && selected_o)
    else $error("write beat outside a sampled bit");
  a_advance_clock_low: assert property (read_advance_o |-> !scl_i && selected_o)
    else $error("read advance outside a read byte");
  a_busy_no_select: assert property ($rose(selected_o) |-> !busy_i)
    else $error("selected while programming");
endmodule

bind serial_eeprom_slave eeprom_slave_checker chk_u (
  .clock_i(clock_i), .reset_i(reset_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o), .busy_i(busy_i), .write_beat_valid_o(write_beat_valid_o),
  .read_advance_o(read_advance_o), .program_start_o(program_start_o),
  .selected_o(selected_o)
);

/* eeprom_bus_master.sv */
// Purpose: behavioural two-wire bus master facing the memory slave
// Assumes: system clock 5 ns; bus bit of 25 system clocks, 125 ns
// Notes: clock parks high between frames; released data reads as pull-up high
`timescale 1ns/1ps
module eeprom_bus_master (
  // clock
  input wire logic clock_i,
  // bus
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // ==========
  // bus primitives, all changes at a falling system edge
  task automatic w(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic bit_x(input logic b, output logic s);
    sda_o = b;
    w(6);
    scl_o = 1'b1;
    w(6);
    s = sda_i;
    w(6);
    scl_o = 1'b0;
    w(7);
  endtask
  task automatic start_c();
    sda_o = 1'b1;
    w(6);
    scl_o = 1'b1;
    w(6);
    sda_o = 1'b0;
    w(6);
    scl_o = 1'b0;
    w(7);
  endtask
  task automatic stop_c();
    sda_o = 1'b0;
    w(6);
    scl_o = 1'b1;
    w(6);
    sda_o = 1'b1;
    w(12);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = !s;
  endtask
  // more low acks the byte; high on the last byte ends the read
  task automatic recv(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(!more, s);
  endtask
endmodule

/* tb_serial_eeprom_slave.sv */
// Purpose: self-checking bench for the two-wire memory slave front end
// Assumes: one address select bit, two compared chip-enable bits
// Notes: read data is a fixed pattern of the address counter
`timescale 1ns/1ps
module tb_serial_eeprom_slave;
  localparam logic [3:0] TID = 4'h9; // arbitrary type code
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic wp = 1'b0;
  logic busy = 1'b0;
  logic scl_w, sda_m, sda_w, sda_o, sda_oe_n_o, bv, ra, ps, sl;
  logic [10:0] addr_w;
  serial_eeprom_pkg::write_beat_type last_beat;
  serial_eeprom_pkg::write_beat_type beat_w;
  int beats = 0;
  int progs = 0;
  int advs = 0;
  int err_total = 0;
  int comparisons = 0;
  always #2.5 clock_i = ~clock_i;
  // open-drain data line with pull-up
  assign sda_w = sda_m & (sda_oe_n_o ? 1'b1 : sda_o);
  eeprom_bus_master mst_u (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl_w), .sda_o(sda_m));
  serial_eeprom_slave #(.TYPE_ID(TID), .HIGH_ADDR_BITS(1)) dut_u (
    .clock_i(clock_i), .reset_i(reset_i), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .chip_sel_pin_0_i(1'b0), .chip_sel_pin_1_i(1'b0),
    .chip_sel_pin_2_i(1'b1), .write_protect_n_i(wp), .busy_i(busy),
    .read_data_i(addr_w[7:0] ^ 8'h3c), .addr_o(addr_w), .write_beat_o(beat_w),
    .write_beat_valid_o(bv), .read_advance_o(ra), .program_start_o(ps), .selected_o(sl));
  always @(posedge clock_i) begin
    if (bv) begin
      last_beat <= beat_w;
      beats <= beats + 1;
    end
    progs <= progs + int'(ps);
    advs <= advs + int'(ra);
  end
  // ==========
  // checking and verdict
  task automatic check_val(input string what, input logic [10:0] e, input logic [10:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [7:0] sel(input logic [2:0] ce, input logic rw);
    return {TID, ce, rw};
  endfunction
  // ==========
  // scenarios
  task automatic s_page_write();
    logic a;
    int p0;
    p0 = progs;
    mst_u.start_c();
    mst_u.send(sel(3'b101, 1'b0), a);
    check_val("select ack", 1'b1, a);
    mst_u.send(8'h0e, a);
    check_val("address ack", 1'b1, a);
    for (int i = 0; i < 3; i++) begin
      mst_u.send(8'h40 + 8'(i), a);
      check_val("data ack", 1'b1, a);
      check_val("beat addr", {7'h10, 4'(14 + i)}, last_beat.addr);
      check_val("beat data", 8'h40 + 8'(i), last_beat.data);
    end
    mst_u.stop_c();
    check_val("program pulses", 11'(p0 + 1), 11'(progs));
  endtask
  task automatic s_protect();
    logic a;
    int b0, p0;
    b0 = beats;
    p0 = progs;
    wp = 1'b1;
    mst_u.start_c();
    mst_u.send(sel(3'b100, 1'b0), a);
    wp = 1'b0;
    check_val("guarded select ack", 1'b1, a);
    mst_u.send(8'h30, a);
    check_val("guarded address ack", 1'b1, a);
    mst_u.send(8'h55, a);
    check_val("guarded data ack", 1'b0, a);
    mst_u.stop_c();
    check_val("guarded beats", 11'(b0), 11'(beats));
    check_val("guarded programs", 11'(p0), 11'(progs));
  endtask
  task automatic s_mismatch();
    logic [7:0] bad [2];
    logic a;
    bad[0] = {~TID, 3'b101, 1'b0};
    bad[1] = sel(3'b011, 1'b0);
    foreach (bad[i]) begin
      mst_u.start_c();
      mst_u.send(bad[i], a);
      check_val("bad select ack", 1'b0, a);
      mst_u.send(sel(3'b101, 1'b0), a);
      check_val("no start ack", 1'b0, a);
      mst_u.stop_c();
    end
    busy = 1'b1;
    mst_u.start_c();
    mst_u.send(sel(3'b101, 1'b0), a);
    check_val("busy select ack", 1'b0, a);
    mst_u.stop_c();
    busy = 1'b0;
  endtask
  task automatic s_rand_read();
    logic a;
    logic [7:0] d;
    int r0;
    r0 = advs;
    wp = 1'b1;
    mst_u.start_c();
    mst_u.send(sel(3'b101, 1'b0), a);
    mst_u.send(8'h25, a);
    mst_u.start_c();
    mst_u.send(sel(3'b101, 1'b1), a);
    check_val("read select ack", 1'b1, a);
    mst_u.recv(1'b1, d);
    check_val("first read", 8'h25 ^ 8'h3c, d);
    mst_u.recv(1'b0, d);
    check_val("next read", 8'h26 ^ 8'h3c, d);
    mst_u.stop_c();
    wp = 1'b0;
    check_val("read advances", 11'(r0 + 2), 11'(advs));
    check_val("standby", 1'b0, sl);
  endtask
  task automatic s_stop_mid();
    logic a;
    int p0, b0;
    p0 = progs;
    b0 = beats;
    mst_u.start_c();
    mst_u.send(sel(3'b101, 1'b0), a);
    mst_u.send(8'h10, a);
    mst_u.send(8'h5a, a);
    check_val("mid byte data ack", 1'b1, a);
    for (int i = 0; i < 4; i++) mst_u.bit_x(1'b1, a);
    mst_u.stop_c();
    check_val("mid byte programs", 11'(p0), 11'(progs));
    check_val("mid byte beats", 11'(b0 + 1), 11'(beats));
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (5) @(negedge clock_i);
    reset_i = 1'b0;
    repeat (8) @(negedge clock_i);
    s_page_write();
    s_protect();
    s_mismatch();
    s_rand_read();
    s_stop_mid();
    give_verdict();
  end
endmodule
